// ### core/an_np_pkg.sv
// Constants and carriers for the auto-negotiation next-page register bank
package an_np_pkg;

  // Register indices on the management port
  localparam logic [4:0] ADDR_ADVERT   = 5'h04;
  localparam logic [4:0] ADDR_EXPANSION = 5'h06;
  localparam logic [4:0] ADDR_NP_TX    = 5'h07;
  localparam logic [4:0] ADDR_NP_RX    = 5'h08;

  // Field positions in the advertisement, expansion, transmit and partner words
  localparam int unsigned BIT_ADV_NP      = 15;
  localparam int unsigned BIT_PAR_FAULT   = 4;
  localparam int unsigned BIT_LP_NP_ABLE  = 3;
  localparam int unsigned BIT_NP_ABLE     = 2;
  localparam int unsigned BIT_PAGE_RX     = 1;
  localparam int unsigned BIT_LP_AN_ABLE  = 0;
  localparam int unsigned BIT_NEXT_PAGE   = 15;
  localparam int unsigned BIT_MSG_PAGE    = 13;
  localparam int unsigned BIT_ACK2        = 12;
  localparam int unsigned BIT_TOGGLE      = 11;
  localparam int unsigned CODE_MSB        = 10;
  localparam int unsigned CODE_W          = 11;

  // Reset values
  localparam logic                RST_ADV_NP    = 1'b0;
  localparam logic                RST_NP_ABLE   = 1'b1;
  localparam logic                RST_TX_NP     = 1'b0;
  localparam logic                RST_TX_MP     = 1'b1;
  localparam logic                RST_TX_ACK2   = 1'b0;
  localparam logic [CODE_W-1:0]   RST_TX_CODE   = 11'h001;
  localparam logic [15:0]         ZERO_WORD     = 16'h0000;

  // One next-page link code word
  typedef struct packed {
    logic              nextPage;
    logic              msgPage;
    logic              ack2;
    logic              toggle;
    logic [CODE_W-1:0] code;
  } np_word_t;

  localparam np_word_t RST_RX_WORD = '{1'b0, 1'b0, 1'b0, 1'b0, 11'h000};

  // Status from the arbitration engine
  typedef struct packed {
    logic pageRxPulse;
    logic parFaultCond;
    logic partnerNpAble;
    logic partnerAnAble;
    logic txToggle;
  } engine_status_t;

  // Management register access request
  typedef struct packed {
    logic        wrStb;
    logic        rdStb;
    logic [4:0]  addr;
    logic [15:0] wrData;
  } mgmt_req_t;

endpackage

// ### core/an_np_regs.sv
// Expansion status and next-page transmit/receive registers
`timescale 1ns/1ps
`default_nettype none

module an_np_regs (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rst_b,
  // Management access
  input  wire an_np_pkg::mgmt_req_t mgmtReq,
  output logic [15:0]              rdData,
  output logic                     rdValid,
  // Negotiation engine
  input  wire an_np_pkg::engine_status_t engStatus,
  input  wire an_np_pkg::np_word_t rxPage,
  output an_np_pkg::np_word_t      txPage,
  output logic                     advertNextPage
);

  // Expansion status state
  logic                pageRx_q;
  logic                pageRx_d;
  logic                parFault_q;
  logic                parFault_d;
  logic                lpNpAble_q;
  logic                lpNpAble_d;
  logic                lpAnAble_q;
  logic                lpAnAble_d;

  // Transmit next-page state
  an_np_pkg::np_word_t tx_q;
  an_np_pkg::np_word_t tx_d;
  logic                txToggle_q;
  logic                txToggle_d;

  // Partner next-page state
  an_np_pkg::np_word_t rx_q;
  an_np_pkg::np_word_t rx_d;

  // Base-page next-page capability
  logic                advNp_q;
  logic                advNp_d;

  // Read port state
  logic [15:0]         rdData_q;
  logic [15:0]         rdData_d;
  logic                rdValid_q;
  logic                rdValid_d;

  // Read-back views and decoded strobes
  logic [15:0]         expWord;
  logic [15:0]         txWord;
  logic [15:0]         rxWord;
  logic [15:0]         advWord;
  logic                rdExp;
  logic                wrTx;
  logic                wrAdv;

  always_comb begin
    expWord = an_np_pkg::ZERO_WORD;
    expWord[an_np_pkg::BIT_PAR_FAULT]  = parFault_q;
    expWord[an_np_pkg::BIT_LP_NP_ABLE] = lpNpAble_q;
    expWord[an_np_pkg::BIT_NP_ABLE]    = an_np_pkg::RST_NP_ABLE;
    expWord[an_np_pkg::BIT_PAGE_RX]    = pageRx_q;
    expWord[an_np_pkg::BIT_LP_AN_ABLE] = lpAnAble_q;
    // Reserved bit 14 stays zero in both words
    txWord = an_np_pkg::ZERO_WORD;
    txWord[an_np_pkg::BIT_NEXT_PAGE] = tx_q.nextPage;
    txWord[an_np_pkg::BIT_MSG_PAGE]  = tx_q.msgPage;
    txWord[an_np_pkg::BIT_ACK2]      = tx_q.ack2;
    txWord[an_np_pkg::BIT_TOGGLE]    = txToggle_q;
    txWord[an_np_pkg::CODE_MSB:0]    = tx_q.code;
    rxWord = an_np_pkg::ZERO_WORD;
    rxWord[an_np_pkg::BIT_NEXT_PAGE] = rx_q.nextPage;
    rxWord[an_np_pkg::BIT_MSG_PAGE]  = rx_q.msgPage;
    rxWord[an_np_pkg::BIT_ACK2]      = rx_q.ack2;
    rxWord[an_np_pkg::BIT_TOGGLE]    = rx_q.toggle;
    rxWord[an_np_pkg::CODE_MSB:0]    = rx_q.code;
    // Only the next-page bit of the base page lives here
    advWord = an_np_pkg::ZERO_WORD;
    advWord[an_np_pkg::BIT_ADV_NP]   = advNp_q;
  end

  // Decoded management strobes
  assign rdExp = mgmtReq.rdStb && (mgmtReq.addr == an_np_pkg::ADDR_EXPANSION);
  assign wrTx  = mgmtReq.wrStb && (mgmtReq.addr == an_np_pkg::ADDR_NP_TX);
  assign wrAdv = mgmtReq.wrStb && (mgmtReq.addr == an_np_pkg::ADDR_ADVERT);

  // Expansion status next values
  always_comb begin
    // page-received and fault flags: read clears, set wins; partner bits follow the engine
    // An event in the cycle of the read must survive, or software misses it
    pageRx_d   = engStatus.pageRxPulse || (pageRx_q && !rdExp);
    parFault_d = engStatus.parFaultCond || (parFault_q && !rdExp);
    lpNpAble_d = engStatus.partnerNpAble;
    lpAnAble_d = engStatus.partnerAnAble;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pageRx_q   <= 1'b0;
      parFault_q <= 1'b0;
      lpNpAble_q <= 1'b0;
      lpAnAble_q <= 1'b0;
    end else begin
      pageRx_q   <= pageRx_d;
      parFault_q <= parFault_d;
      lpNpAble_q <= lpNpAble_d;
      lpAnAble_q <= lpAnAble_d;
    end
  end

  // Transmit word next values
  always_comb begin
    txToggle_d = engStatus.txToggle;
    tx_d       = tx_q;
    // writable transmit fields
    // Toggle and reserved bit 14 never come from the write data
    if (wrTx) begin
      tx_d.nextPage = mgmtReq.wrData[an_np_pkg::BIT_NEXT_PAGE];
      tx_d.msgPage  = mgmtReq.wrData[an_np_pkg::BIT_MSG_PAGE];
      tx_d.ack2     = mgmtReq.wrData[an_np_pkg::BIT_ACK2];
      tx_d.code     = mgmtReq.wrData[an_np_pkg::CODE_MSB:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_q       <= '{an_np_pkg::RST_TX_NP, an_np_pkg::RST_TX_MP, an_np_pkg::RST_TX_ACK2,
                      1'b0, an_np_pkg::RST_TX_CODE};
      txToggle_q <= 1'b0;
    end else begin
      tx_q       <= tx_d;
      txToggle_q <= txToggle_d;
    end
  end

  // Partner word next value
  always_comb begin
    // capture partner page
    // Loads only on a received page, so a read between pages sees a steady word
    rx_d = engStatus.pageRxPulse ? rxPage : rx_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_q <= an_np_pkg::RST_RX_WORD;
    end else begin
      rx_q <= rx_d;
    end
  end

  // Base-page capability next value
  always_comb begin
    advNp_d = advNp_q;
    if (wrAdv) begin
      advNp_d = mgmtReq.wrData[an_np_pkg::BIT_ADV_NP];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      advNp_q <= an_np_pkg::RST_ADV_NP;
    end else begin
      advNp_q <= advNp_d;
    end
  end

  // Read port next values
  always_comb begin
    // unmapped indices read zero
    // Read data holds between reads; a read in a write cycle sees the old word
    rdValid_d = mgmtReq.rdStb;
    rdData_d  = rdData_q;
    if (mgmtReq.rdStb) begin
      unique case (mgmtReq.addr)
        an_np_pkg::ADDR_ADVERT:    rdData_d = advWord;
        an_np_pkg::ADDR_EXPANSION: rdData_d = expWord;
        an_np_pkg::ADDR_NP_TX:     rdData_d = txWord;
        an_np_pkg::ADDR_NP_RX:     rdData_d = rxWord;
        default:                   rdData_d = an_np_pkg::ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_q  <= an_np_pkg::ZERO_WORD;
      rdValid_q <= 1'b0;
    end else begin
      rdData_q  <= rdData_d;
      rdValid_q <= rdValid_d;
    end
  end

  // Engine sees the stored transmit word with the tracked toggle
  assign txPage = '{tx_q.nextPage, tx_q.msgPage, tx_q.ack2, txToggle_q, tx_q.code};
  assign advertNextPage = advNp_q;
  assign rdData  = rdData_q;
  assign rdValid = rdValid_q;

endmodule

`default_nettype wire

// ### verification/an_np_regs_asserts.sv
// Port assertions for the next-page register bank
`timescale 1ns/1ps
`default_nettype none
module an_np_regs_asserts (
  // Clock and reset
  input wire logic                      clk,
  input wire logic                      rst_b,
  // Watched ports
  input wire an_np_pkg::mgmt_req_t      mgmtReq,
  input wire logic [15:0]               rdData,
  input wire logic                      rdValid,
  input wire an_np_pkg::engine_status_t engStatus,
  input wire an_np_pkg::np_word_t       rxPage,
  input wire an_np_pkg::np_word_t       txPage,
  input wire logic                      advertNextPage
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire logic rd6 = mgmtReq.rdStb && mgmtReq.addr == 5'h06;
  wire logic rd8 = mgmtReq.rdStb && mgmtReq.addr == 5'h08;
  sequence s_rx6; engStatus.pageRxPulse ##1 !rd6 ##1 rd6; endsequence
  sequence s_rx8; engStatus.pageRxPulse ##1 !engStatus.pageRxPulse ##1 rd8; endsequence
  a_read_answer: assert property (
    rdValid == $past(mgmtReq.rdStb)) else $error("read answer timing off");
  a_np_able_one: assert property (
    rd6 |=> rdData[2] && rdData[15:5] == 11'h000) else $error("expansion fixed bits off");
  a_page_rx_set: assert property (
    s_rx6 |=> rdData[1]) else $error("page received not latched");
  a_fault_set: assert property (
    engStatus.parFaultCond ##1 rd6 |=> rdData[4]) else $error("fault flag not latched");
  a_rx_load: assert property (
    s_rx8 |=> rdData == {$past(rxPage[14], 3), 1'b0, $past(rxPage[13:0], 3)})
    else $error("partner word wrong");
  a_tx_toggle: assert property (
    $changed(engStatus.txToggle) |=> txPage.toggle == $past(engStatus.txToggle))
    else $error("toggle not followed");
  a_tx_write: assert property (
    mgmtReq.wrStb && mgmtReq.addr == 5'h07 |=> txPage.code == $past(mgmtReq.wrData[10:0])
    && txPage.ack2 == $past(mgmtReq.wrData[12])) else $error("transmit write lost");
  a_ro_write: assert property (
    mgmtReq.wrStb && mgmtReq.addr != 5'h07 |=> $stable(txPage.code) && $stable(txPage.ack2))
    else $error("transmit word hit by other write");
endmodule
bind an_np_regs an_np_regs_asserts u_an_np_regs_asserts (.*);
`default_nettype wire

// ### verification/mgmt_host.sv
// Management controller model issuing register cycles
`timescale 1ns/1ps
`default_nettype none
module mgmt_host (
  // Clock
  input wire logic                 clk,
  // Register port
  output var an_np_pkg::mgmt_req_t req,
  input wire logic [15:0]          rdData,
  input wire logic                 rdValid
);
  initial req = '0;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk) req = '{1'b1, 1'b0, a, d};
    @(negedge clk) req.wrStb = 1'b0;
  endtask
  // Missing answer reads as unknown so it never matches
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk) req = '{1'b0, 1'b1, a, 16'h0000};
    @(negedge clk) req.rdStb = 1'b0;
    d = rdValid ? rdData : 'x;
  endtask
endmodule
`default_nettype wire

// ### verification/an_np_regs_tb.sv
// Self-checking bench for the next-page register bank
`timescale 1ns/1ps
`default_nettype none
module an_np_regs_tb;
  logic                      clk, rst_b, rdValid, advertNextPage;
  logic [15:0]               rdData, got;
  an_np_pkg::mgmt_req_t      mgmtReq;
  an_np_pkg::engine_status_t engStatus;
  an_np_pkg::np_word_t       rxPage, txPage;
  int                        mismatches, checked, cycles;
  an_np_regs u_an_np_regs (.clk(clk), .rst_b(rst_b), .mgmtReq(mgmtReq), .rdData(rdData),
    .rdValid(rdValid), .engStatus(engStatus), .rxPage(rxPage), .txPage(txPage),
    .advertNextPage(advertNextPage));
  mgmt_host u_mgmt_host (.clk(clk), .req(mgmtReq), .rdData(rdData), .rdValid(rdValid));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
    u_mgmt_host.rd(a, got);
    check(got, exp);
  endtask
  task automatic pulse;
    @(negedge clk) engStatus.pageRxPulse = 1'b1;
    @(negedge clk) engStatus.pageRxPulse = 1'b0;
  endtask
  task automatic t_pages;
    rxPage = '{1'b1, 1'b1, 1'b1, 1'b1, 11'h5A5};
    engStatus.partnerAnAble = 1'b1;
    engStatus.partnerNpAble = 1'b1;
    pulse();
    rdchk(5'h08, 16'hBDA5);
    pulse();
    rdchk(5'h06, 16'h000F);
    rdchk(5'h06, 16'h000D);
    engStatus.partnerNpAble = 1'b0;
    rdchk(5'h06, 16'h0005);
    engStatus.parFaultCond = 1'b1;
    rdchk(5'h06, 16'h0015);
    engStatus.parFaultCond = 1'b0;
    rdchk(5'h06, 16'h0015);
    rdchk(5'h06, 16'h0005);
    $display("test pages done");
  endtask
  task automatic t_writes;
    u_mgmt_host.wr(5'h07, 16'hFFFF);
    rdchk(5'h07, 16'hB7FF);
    check({1'b0, txPage}, 16'h77FF);
    engStatus.txToggle = 1'b1;
    rdchk(5'h07, 16'hBFFF);
    u_mgmt_host.wr(5'h07, 16'h0000);
    rdchk(5'h07, 16'h0800);
    u_mgmt_host.wr(5'h08, 16'hFFFF);
    u_mgmt_host.wr(5'h06, 16'hFFFF);
    rdchk(5'h08, 16'hBDA5);
    rdchk(5'h06, 16'h0005);
    u_mgmt_host.wr(5'h04, 16'hFFFF);
    check({15'h0000, advertNextPage}, 16'h0001);
    rdchk(5'h04, 16'h8000);
    rdchk(5'h1F, 16'h0000);
    $display("test writes done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Whole run needs well under a hundred cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    rst_b = 1'b0;
    engStatus = '0;
    rxPage = '0;
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    rdchk(5'h06, 16'h0004);
    rdchk(5'h07, 16'h2001);
    rdchk(5'h08, 16'h0000);
    rdchk(5'h04, 16'h0000);
    $display("test reset done");
    t_pages();
    t_writes();
    wrap_up();
  end
endmodule
`default_nettype wire
